//--- pkg/srec_pkg.sv
package srec_pkg;
  // ASCII codes that the parser watches
  localparam logic [7:0] CHAR_S = 8'h53;
  localparam logic [7:0] CHAR_S_LOWER = 8'h73;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_NUL = 8'h00;
  localparam logic [7:0] CHAR_0 = 8'h30;
  localparam logic [7:0] CHAR_9 = 8'h39;
  localparam logic [7:0] CHAR_UA = 8'h41;
  localparam logic [7:0] CHAR_UF = 8'h46;
  localparam logic [7:0] CHAR_LA = 8'h61;
  localparam logic [7:0] CHAR_LF_HEX = 8'h66;
  localparam logic [7:0] HEX_ALPHA_OFS = 8'h0A;
  // Record kinds
  localparam logic [3:0] KIND_HEADER = 4'h0;
  localparam logic [3:0] KIND_DATA16 = 4'h1;
  localparam logic [3:0] KIND_END16 = 4'h9;
  // Field sizes in bytes, and the entry reset value
  localparam logic [7:0] ADDR16_BYTES = 8'h02;
  localparam logic [7:0] CSUM_BYTES = 8'h01;
  localparam logic [7:0] MIN_LEN16 = 8'h03;
  localparam logic [15:0] ENTRY_RESET = 16'h0000;

  // Incoming character
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } char_t;

  // Memory write request
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } memWrite_t;

  // Status of the loader
  typedef struct packed {
    logic loading;
    logic done;
    logic csumError;
    logic lenError;
    logic formatError;
    logic [15:0] entry;
  } loadStatus_t;
endpackage : srec_pkg

//--- rtl/reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
  // Clock and raw reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Released copy
  output logic rstSync_n
);
  logic [1:0] stages;

  // Assert at once, release after two edges to avoid metastable release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stages <= 2'b00;
    end else begin
      stages <= {stages[0], 1'b1};
    end
  end

  assign rstSync_n = stages[1];
endmodule : reset_sync
`default_nettype wire

//--- rtl/srecord_download_parser.sv
// Behaviour
// - Byte is two hex digits, high first
// - Record begins with S and kind digit
// - Length counts address, payload and checksum pairs
// - Address is always two bytes, as in S1 and S9
// - Checksum is complemented low byte sum
// - Accept payloads of zero or more bytes
// - CR, LF, NUL terminate, not content
// - Skip leading junk, resync on S
// - Only S1 data and S9 end act
// - Ignore everything before first data record
// - Header records write nothing to memory
// - Data bytes written at incrementing addresses
// - Kinds two through eight never load
// - End record address becomes entry point
// - One end record, many headers allowed
// - Check pair count and checksum
// - Characters arrive as eight-bit ASCII
`timescale 1ns/1ps
`default_nettype none
module srecord_download_parser
  import srec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Character stream from the serial port
  input wire char_t rxChar,
  // Sticky error clear
  input wire logic clearErrors,
  // Restart for a new download
  input wire logic restart,
  // Memory write port
  output memWrite_t memWrite,
  // Load status
  output loadStatus_t status
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_KIND = 6'b000010,
    ST_HIGH = 6'b000100,
    ST_LOW = 6'b001000,
    ST_SKIP = 6'b010000,
    ST_DONE = 6'b100000
  } state_t;

  typedef struct packed {
    state_t state;
    logic [3:0] kind;
    logic [3:0] highNibble;
    logic [7:0] byteIndex;
    logic [7:0] length;
    logic [7:0] sum;
    logic [15:0] addr;
    memWrite_t memWrite;
    loadStatus_t status;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic rstSync_n;
  logic isHex;
  logic [3:0] nibble;
  logic [7:0] byteVal;
  logic [7:0] next_sum;
  logic isTerm;
  logic isStart;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage release of the reset
  reset_sync resetSync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rstSync_n(rstSync_n)
  );

  // Hex digit test, either case accepted
  function automatic logic hexValid(input logic [7:0] c);
    hexValid = (c >= CHAR_0 && c <= CHAR_9) ||
               (c >= CHAR_UA && c <= CHAR_UF) ||
               (c >= CHAR_LA && c <= CHAR_LF_HEX);
  endfunction : hexValid

  // Hex digit value; caller checks validity first
  function automatic logic [3:0] hexValue(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (c <= CHAR_9) begin
      v = c - CHAR_0;
    end else if (c <= CHAR_UF) begin
      v = c - CHAR_UA + HEX_ALPHA_OFS;
    end else begin
      v = c - CHAR_LA + HEX_ALPHA_OFS;
    end
    hexValue = v[3:0];
  endfunction : hexValue

  ////////////////////////////////////////////////////////////////////////////
  // Character classification, all codes taken as 8-bit ASCII
  always_comb begin
    isHex = hexValid(rxChar.code);
    nibble = hexValue(rxChar.code);
    byteVal = {r.highNibble, nibble};
    next_sum = r.sum + byteVal;
    isTerm = (rxChar.code == CHAR_CR) || (rxChar.code == CHAR_LF) ||
             (rxChar.code == CHAR_NUL);
    isStart = (rxChar.code == CHAR_S) || (rxChar.code == CHAR_S_LOWER);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole parser
  always_comb begin
    next_r = r;
    next_r.memWrite.valid = 1'b0;
    // Clear loses to a fresh error in the same cycle
    if (clearErrors) begin
      next_r.status.csumError = 1'b0;
      next_r.status.lenError = 1'b0;
      next_r.status.formatError = 1'b0;
    end
    if (restart) begin
      next_r.state = ST_IDLE;
      next_r.status.loading = 1'b0;
      next_r.status.done = 1'b0;
      next_r.status.entry = ENTRY_RESET;
    end else if (rxChar.valid) begin
      unique case (r.state)
        // Hunt for a record start; line numbers and junk fall through
        ST_IDLE, ST_SKIP: begin
          if (isStart) begin
            next_r.state = ST_KIND;
          end
        end
        ST_KIND: begin
          if (!isHex) begin
            next_r.state = ST_IDLE;
            next_r.status.formatError = 1'b1;
          end else begin
            next_r.kind = nibble;
            next_r.byteIndex = 8'h00;
            next_r.sum = 8'h00;
            // Before the first S1 only an S1 is worth parsing
            if (!r.status.loading && nibble != KIND_DATA16) begin
              next_r.state = ST_SKIP;
            end else if (r.status.loading && nibble != KIND_DATA16 &&
                         nibble != KIND_END16) begin
              next_r.state = ST_SKIP;
            end else begin
              next_r.state = ST_HIGH;
            end
          end
        end
        ST_HIGH: begin
          if (isHex) begin
            next_r.highNibble = nibble;
            next_r.state = ST_LOW;
          end else if (isTerm) begin
            // Record ended short of its length
            next_r.state = ST_IDLE;
            next_r.status.lenError = 1'b1;
          end else begin
            next_r.state = ST_IDLE;
            next_r.status.formatError = 1'b1;
          end
        end
        ST_LOW: begin
          if (!isHex) begin
            next_r.state = ST_IDLE;
            next_r.status.formatError = 1'b1;
          end else begin
            next_r.state = ST_HIGH;
            next_r.byteIndex = r.byteIndex + 8'h01;
            next_r.sum = next_sum;
            if (r.byteIndex == 8'h00) begin
              // Length byte; 16-bit records need address and checksum
              next_r.length = byteVal;
              if (byteVal < MIN_LEN16) begin
                next_r.state = ST_IDLE;
                next_r.status.lenError = 1'b1;
              end
            end else if (r.byteIndex == 8'h01) begin
              next_r.addr = {byteVal, 8'h00};
            end else if (r.byteIndex == 8'h02) begin
              next_r.addr = {r.addr[15:8], byteVal};
            end else if (r.byteIndex == r.length) begin
              // Checksum byte closes the record
              next_r.state = ST_SKIP;
              if (~r.sum != byteVal) begin
                next_r.status.csumError = 1'b1;
              end else if (r.kind == KIND_END16) begin
                next_r.state = ST_DONE;
                next_r.status.done = 1'b1;
                next_r.status.loading = 1'b0;
                next_r.status.entry = r.addr;
              end else begin
                next_r.status.loading = 1'b1;
              end
            end else if (r.kind == KIND_DATA16) begin
              // Payload byte; write at once, checksum judged at end
              next_r.memWrite.valid = 1'b1;
              next_r.memWrite.addr = r.addr;
              next_r.memWrite.data = byteVal;
              next_r.addr = r.addr + 16'h0001;
            end
          end
        end
        // Transfer over; everything else waits for a restart
        ST_DONE: begin
          next_r.state = ST_DONE;
        end
        default: begin
          next_r.state = ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      r <= '{state: ST_IDLE, kind: 4'h0, highNibble: 4'h0,
             byteIndex: 8'h00, length: 8'h00, sum: 8'h00,
             addr: 16'h0000,
             memWrite: '{valid: 1'b0, addr: 16'h0000, data: 8'h00},
             status: '{loading: 1'b0, done: 1'b0, csumError: 1'b0,
                       lenError: 1'b0, formatError: 1'b0,
                       entry: ENTRY_RESET}};
    end else begin
      r <= next_r;
    end
  end

  assign memWrite = r.memWrite;
  assign status = r.status;
endmodule : srecord_download_parser
`default_nettype wire

//--- tb/srec_parser_properties.sv
`timescale 1ns/1ps
`default_nettype none
module srec_parser_properties
  import srec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire char_t rxChar,
  input wire logic clearErrors,
  input wire logic restart,
  input wire memWrite_t memWrite,
  input wire loadStatus_t status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // A byte needs two digits, so writes never abut
  property p_wrPulse; memWrite.valid |=> !memWrite.valid; endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write too long");
  property p_wrCause; memWrite.valid |-> $past(rxChar.valid); endproperty
  a_wrCause: assert property (p_wrCause) else $error("write uncaused");
  property p_doneCause; $rose(status.done) |-> $past(rxChar.valid); endproperty
  a_doneCause: assert property (p_doneCause) else $error("done uncaused");
  property p_doneQuiet; status.done && !restart |=> !memWrite.valid;
  endproperty
  a_doneQuiet: assert property (p_doneQuiet) else $error("write after end");
  property p_restart;
    restart |=> !status.loading && !status.done && status.entry == ENTRY_RESET;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");
  property p_csumHold;
    status.csumError && !clearErrors && !restart |=> status.csumError;
  endproperty
  a_csumHold: assert property (p_csumHold) else $error("error not held");
  // A char in the same cycle can still set a flag over the clear
  property p_clear; clearErrors && !rxChar.valid && !$past(rxChar.valid) |=>
    !status.csumError && !status.lenError && !status.formatError; endproperty
  a_clear: assert property (p_clear) else $error("errors not cleared");
  property p_fmtCause; $rose(status.formatError) |-> $past(rxChar.valid);
  endproperty
  a_fmtCause: assert property (p_fmtCause) else $error("format uncaused");
  property p_loadCause; $rose(status.loading) |-> $past(rxChar.valid);
  endproperty
  a_loadCause: assert property (p_loadCause) else $error("load uncaused");
  c_write: cover property (memWrite.valid);
  c_done: cover property (status.done);
  c_csum: cover property (status.csumError);
endmodule : srec_parser_properties
bind srecord_download_parser srec_parser_properties srec_parser_properties_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .rxChar(rxChar),
  .clearErrors(clearErrors), .restart(restart), .memWrite(memWrite),
  .status(status));
`default_nettype wire

//--- tb/srec_host.sv
`timescale 1ns/1ps
`default_nettype none
module srec_host
  import srec_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Character stream
  output var char_t rxChar
);
  int seed = 32'h0314;
  initial rxChar = '0;
  // ASCII codes in string order; idle line shows junk, not the last code
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_sys);
      rxChar <= '{1'b1, s[i]};
      // Random gaps stand for a slow host
      if ($random(seed) & 1) begin
        @(posedge clk_sys);
        rxChar <= '{1'b0, ~s[i]};
      end
    end
    @(posedge clk_sys);
    rxChar <= '{1'b0, ~s[s.len() - 1]};
  endtask : send
endmodule : srec_host
`default_nettype wire

//--- tb/srecord_download_parser_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module srecord_download_parser_tb_top
  import srec_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clearErrors = 1'b0;
  logic restart = 1'b0;
  char_t rxChar;
  memWrite_t memWrite;
  loadStatus_t status;
  int failures = 0;
  int check_count = 0;
  int seed = 32'h0314;
  logic [23:0] expQ[$];
  always #2.5 clk_sys = ~clk_sys;
  srec_host srec_host_i (.clk_sys(clk_sys), .rxChar(rxChar));
  srecord_download_parser srecord_download_parser_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .rxChar(rxChar), .clearErrors(clearErrors),
    .restart(restart), .memWrite(memWrite), .status(status));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // One record with its checksum; bad flips the low bit
  function automatic string rec(input int kind, input logic [15:0] a,
      input logic [7:0] d[$], input bit bad);
    logic [7:0] sum;
    string s;
    sum = 8'(d.size() + 3) + a[15:8] + a[7:0];
    s = $sformatf("S%0d%02X%04X", kind, d.size() + 3, a);
    foreach (d[i]) begin
      sum += d[i];
      s = {s, $sformatf("%02X", d[i])};
    end
    return {s, $sformatf("%02X\r\n", ~sum ^ {7'h00, bad})};
  endfunction : rec
  task automatic snd(input string s);
    srec_host_i.send(s);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : snd
  // Notes the writes a record should make, then sends it
  task automatic data(input logic [15:0] a, input logic [7:0] d[$],
      input bit bad, input bit live);
    if (live) foreach (d[i]) expQ.push_back({a + 16'(i), d[i]});
    snd(rec(1, a, d, bad));
  endtask : data
  task automatic clr;
    @(posedge clk_sys);
    clearErrors <= 1'b1;
    @(posedge clk_sys);
    clearErrors <= 1'b0;
  endtask : clr
  // Each write takes the oldest note
  always @(posedge clk_sys) begin
    if (memWrite.valid === 1'b1) begin
      if (expQ.size() == 0) chk("spare write", 24'h1, 24'h0);
      else chk("write", {memWrite.addr, memWrite.data}, expQ.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d[$];
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Line number, junk and two headers come first
    snd("x 12 S00600004844521B\r\nS00600004844521B\r\n");
    data(16'h0030, '{8'h00, 8'h14, 8'h4E, 8'hD4}, 0, 1);
    chk("flags", 24'(status >> 16), 24'h10);
    // Payloads of 0, 1, 2 and 28 bytes
    for (int n = 0; n < 4; n++) begin
      d = {};
      repeat (n == 3 ? 28 : n) d.push_back(8'($random(seed)));
      data(16'($random(seed)), d, 0, 1);
    end
    // Lower-case start letter and digits must load as well
    expQ.push_back({16'h0050, 8'hAB});
    snd("s1040050ab00\r\n");
    snd("S5030004F8\r\n");
    data(16'h1234, '{8'hA5}, 1, 1);
    chk("flags", 24'(status >> 16), 24'h14);
    clr();
    snd("S10G\r\n");
    chk("flags", 24'(status >> 16), 24'h11);
    clr();
    snd("S1020000FD\r\n");
    chk("flags", 24'(status >> 16), 24'h12);
    clr();
    snd("S9030100FB\r\n");
    chk("entry", 24'(status.entry), 24'h0100);
    chk("done", 24'(status.done), 24'h1);
    data(16'h0040, '{8'h11}, 0, 0);
    @(posedge clk_sys);
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
    @(negedge clk_sys);
    chk("restart", 24'({status.loading, status.done, status.entry}), 24'h0);
    chk("left", 24'(expQ.size()), 24'h0);
    give_verdict();
  end
  // Hang guard, about 80k cycles
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule : srecord_download_parser_tb_top
`default_nettype wire
